// ===== uart_ldev_regs.vh
// Register map constants for the UART logical device configuration bank.
// Included by the bank and its clock generator; definitions only.
`ifndef UART_LDEV_REGS_VH
`define UART_LDEV_REGS_VH

// Register indices; byte address is (bank * 256 + index) * 4
`define IDX_ACTIVATE 8'h30
`define IDX_BASE_HIGH 8'h60
`define IDX_BASE_LOW 8'h61
`define IDX_IRQ_SELECT 8'h70
`define IDX_OPTIONS 8'hf0
// Interrupt block lives in bank 3
`define IDX_INT_STATUS 8'h00
`define IDX_INT_MASK 8'h04
`define BANK_UART_D 2'h0
`define BANK_UART_E 2'h1
`define BANK_UART_F 2'h2
`define BANK_INT 2'h3

// Reset values, per device
`define RST_ACTIVATE 8'h00
`define RST_BASE_HIGH_D 8'h02
`define RST_BASE_LOW_D 8'he0
`define RST_BASE_HIGH_E 8'h03
`define RST_BASE_LOW_E 8'he8
`define RST_BASE_HIGH_F 8'h02
`define RST_BASE_LOW_F 8'he8
`define RST_IRQ_SELECT_D 8'h03
`define RST_IRQ_SELECT_E 8'h04
`define RST_IRQ_SELECT_F 8'h03
`define RST_OPTIONS 8'h00
`define RST_INT_MASK 8'h00

// Field positions
`define ACT_BIT 0
`define OPT_RX_NODELAY_BIT 7
`define OPT_IRQ_PULSE_BIT 6
`define OPT_NEW_FIFO_ERR_BIT 5
`define OPT_CLK_SEL_MSB 1
`define OPT_CLK_SEL_LSB 0
`define IRQ_SEL_MSB 3
`define BASE_HIGH_MSB 3
`define BASE_LOW_ALIGN 3

// Lowest legal base address
`define BASE_MIN 12'h100

// Clock select codes and reference step / modulus for each
`define CLK_DIV13 2'h0
`define CLK_DIV12 2'h1
`define CLK_DIV1 2'h2
`define CLK_DIV1P625 2'h3
`define STEP_UNIT 5'h01
`define STEP_EIGHT 5'h08
`define MOD_13 5'h0d
`define MOD_12 5'h0c
`define MOD_1 5'h01

`endif

// ===== uart_clk_gen.v
// Fractional divider turning 24 MHz reference ticks into UART clock ticks.
// Assumes ref_tick is already synchronised to sys_clk, one cycle per edge.
`timescale 1ns/10ps
`default_nettype none
`include "uart_ldev_regs.vh"

module uart_clk_gen
(
   input wire sys_clk,
   input wire reset_n,
   input wire ref_tick,
   input wire [1:0] clk_sel,
   output reg tick_q
);

   reg [4:0] acc_q; // Phase accumulator, below modulus except just after a code switch
   reg [4:0] step; // Added per reference tick
   reg [4:0] modulus; // Wraps the accumulator
   reg [4:0] sum; // Accumulator plus step

   // Step and modulus per select code; 1.625 is done as 8/13
   always @*
   begin
      sum = 5'h00;
      case (clk_sel)
         `CLK_DIV13:
         begin
            step = `STEP_UNIT;
            modulus = `MOD_13;
         end
         `CLK_DIV12:
         begin
            step = `STEP_UNIT;
            modulus = `MOD_12;
         end
         `CLK_DIV1:
         begin
            step = `STEP_UNIT;
            modulus = `MOD_1;
         end
         default:
         begin
            step = `STEP_EIGHT;
            modulus = `MOD_13;
         end
      endcase
      sum = acc_q + step;
   end

   // Tick when the accumulator wraps; jitter of one ref tick on /1.625
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         acc_q <= 5'h00;
         tick_q <= 1'b0;
      end
      else if (ref_tick)
      begin
         if (sum >= modulus)
         begin
            acc_q <= sum - modulus;
            tick_q <= 1'b1;
         end
         else
         begin
            acc_q <= sum;
            tick_q <= 1'b0;
         end
      end
      else
      begin
         // Switching codes mid-count may leave a large remainder; clear it to zero
         if (acc_q >= modulus)
            acc_q <= 5'h00;
         tick_q <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ===== uart_ldev_cfg.v
// Configuration bank for UART logical devices D, E and F, Wishbone slave.
// Assumes a classic Wishbone master on sys_clk; io_addr and ref_tick are pins.
//
// Overview of operation
// R1: Activate bit zero enables device, resets inactive
// R2: Base address window 100h..FF8h, 8-byte aligned
// R3: Base resets D 02E0h, E 03E8h, F 02E8h
// R4: Irq select bits 3..0 pick line, upper reserved
// R5: Irq select resets D 03h, E 04h, F 03h
// R6: Option bit 6 chooses level or pulse irq
// R7: Option bit 5 chooses original or revised error
// R8: Clock code 00 divides by 13, 01 by 12
// R9: Device D bit 7 clear adds receive delay
// R10: Option register resets zero, bits 4..2 reserved
// R11: Code 10 passes reference, 11 divides 1.625
// R12: High then low byte, low three bits zero
`timescale 1ns/10ps
`default_nettype none
`include "uart_ldev_regs.vh"

module uart_ldev_cfg
#(
   parameter NUM_DEV = 3, // Devices D, E, F
   parameter NUM_OPT = 2 // Devices with an option register: D, E
)
(
   input wire sys_clk,
   input wire reset_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg irq_o,
   input wire [11:0] io_addr,
   input wire io_addr_valid,
   input wire ref_tick,
   input wire [1:0] uart_irq_req,
   input wire [1:0] rx_fifo_err_orig,
   input wire [1:0] rx_fifo_err_new,
   output reg [2:0] dev_active_q,
   output reg [35:0] dev_base_q,
   output reg [11:0] irq_line_q,
   output reg [2:0] io_select_q,
   output reg [1:0] uart_irq_q,
   output reg [1:0] line_status_err_q,
   output reg rx_delay_en_q,
   output wire [1:0] uart_clk_tick_q
);

   // Register storage
   reg [NUM_DEV-1:0] act_q; // Activate bits
   reg [4*NUM_DEV-1:0] base_hi_q; // Base address bits 11..8
   reg [5*NUM_DEV-1:0] base_lo_q; // Base address bits 7..3
   reg [4*NUM_DEV-1:0] irq_sel_q; // Irq line selectors
   reg [5*NUM_OPT-1:0] opt_q; // Options {b7,b6,b5,b1,b0}
   reg [5:0] int_stat_q; // Sticky events
   reg [5:0] int_mask_q; // Event enables
   reg [NUM_DEV-1:0] base_ok_q; // Previous in-range state

   // Pin synchronisers, first stage read only by second
   reg [12:0] io_meta_q;
   reg [12:0] io_sync_q;
   reg ref_meta_q;
   reg ref_sync_q;

   reg [1:0] irq_req_prev_q; // For pulse mode edges

   // Bus decode
   wire [1:0] bank = wb_adr_i[11:10];
   wire [7:0] idx = wb_adr_i[9:2];
   wire bus_req = wb_cyc_i & wb_stb_i;
   // Write commits on the edge where ack is seen high
   wire wr_commit = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
   wire rd_commit = bus_req & wb_ack_o & ~wb_we_i;

   // Decode helper used for every register write and the status read
   function hit;
      input [1:0] b;
      input [7:0] i;
      input [1:0] want_b;
      input [7:0] want_i;
      begin
         hit = (b == want_b) && (i == want_i);
      end
   endfunction

   // Reset value of each device's base high byte
   function [7:0] rst_base_hi;
      input integer d;
      begin
         if (d == 0)
            rst_base_hi = `RST_BASE_HIGH_D;
         else if (d == 1)
            rst_base_hi = `RST_BASE_HIGH_E;
         else
            rst_base_hi = `RST_BASE_HIGH_F;
      end
   endfunction

   // Reset value of each device's base low byte
   function [7:0] rst_base_lo;
      input integer d;
      begin
         if (d == 0)
            rst_base_lo = `RST_BASE_LOW_D;
         else if (d == 1)
            rst_base_lo = `RST_BASE_LOW_E;
         else
            rst_base_lo = `RST_BASE_LOW_F;
      end
   endfunction

   // Reset value of each device's irq selector
   function [7:0] rst_irq_sel;
      input integer d;
      begin
         if (d == 1)
            rst_irq_sel = `RST_IRQ_SELECT_E;
         else if (d == 0)
            rst_irq_sel = `RST_IRQ_SELECT_D;
         else
            rst_irq_sel = `RST_IRQ_SELECT_F;
      end
   endfunction

   // Bank code of a device number
   function [1:0] bank_of;
      input integer d;
      begin
         bank_of = d[1:0];
      end
   endfunction

   wire [11:0] base_full [0:NUM_DEV-1]; // Assembled base per device
   wire [NUM_DEV-1:0] base_ok; // In legal window
   wire [NUM_DEV-1:0] act_evt; // Activate bit changed this edge

   // Per-device registers
   genvar g;
   generate
      for (g = 0; g < NUM_DEV; g = g + 1)
      begin : dev
         wire [7:0] rhi = rst_base_hi(g);
         wire [7:0] rlo = rst_base_lo(g);
         wire [7:0] rsel = rst_irq_sel(g);
         wire [7:0] ract = `RST_ACTIVATE; // Full byte; only the activate bit is stored
         wire wr_act = wr_commit & hit(bank, idx, bank_of(g), `IDX_ACTIVATE);
         // High byte first, low byte second, three zero bits below
         assign base_full[g] = {base_hi_q[4*g+3:4*g], base_lo_q[5*g+4:5*g], 3'h0}; // R12
         assign base_ok[g] = base_full[g] >= `BASE_MIN; // R2
         assign act_evt[g] = wr_act & (wb_dat_i[`ACT_BIT] != act_q[g]);

         always @(posedge sys_clk)
         begin
            if (!reset_n)
            begin
               act_q[g] <= ract[`ACT_BIT]; // R1
               base_hi_q[4*g+3:4*g] <= rhi[`BASE_HIGH_MSB:0]; // R3
               base_lo_q[5*g+4:5*g] <= rlo[7:`BASE_LOW_ALIGN]; // R3
               irq_sel_q[4*g+3:4*g] <= rsel[`IRQ_SEL_MSB:0]; // R5
            end
            else
            begin
               // Activate bit
               if (wr_act)
                  act_q[g] <= wb_dat_i[`ACT_BIT]; // R1
               // Base high byte; upper nibble has no storage
               if (wr_commit & hit(bank, idx, bank_of(g), `IDX_BASE_HIGH))
                  base_hi_q[4*g+3:4*g] <= wb_dat_i[`BASE_HIGH_MSB:0]; // R2
               // Base low byte; alignment bits dropped
               if (wr_commit & hit(bank, idx, bank_of(g), `IDX_BASE_LOW))
                  base_lo_q[5*g+4:5*g] <= wb_dat_i[7:`BASE_LOW_ALIGN]; // R12
               // Irq line selector
               if (wr_commit & hit(bank, idx, bank_of(g), `IDX_IRQ_SELECT))
                  irq_sel_q[4*g+3:4*g] <= wb_dat_i[`IRQ_SEL_MSB:0]; // R4
            end
         end
      end
   endgenerate

   // Option registers for D and E
   generate
      for (g = 0; g < NUM_OPT; g = g + 1)
      begin : opt
         wire [7:0] ropt = `RST_OPTIONS; // Reserved bits 4..2 have no storage
         always @(posedge sys_clk)
         begin
            if (!reset_n)
               opt_q[5*g+4:5*g] <= {ropt[7:5], ropt[1:0]}; // R10
            else if (wr_commit & hit(bank, idx, bank_of(g), `IDX_OPTIONS))
            begin
               // Bit 7 stored on E too but never read there
               opt_q[5*g+4:5*g] <= {wb_dat_i[`OPT_RX_NODELAY_BIT], wb_dat_i[`OPT_IRQ_PULSE_BIT],
                  wb_dat_i[`OPT_NEW_FIFO_ERR_BIT], wb_dat_i[`OPT_CLK_SEL_MSB:`OPT_CLK_SEL_LSB]}; // R10
            end
         end

         // UART clock divider of the reference
         uart_clk_gen u_clk
         (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .ref_tick(ref_sync_q),
            .clk_sel(opt_q[5*g+1:5*g]),
            .tick_q(uart_clk_tick_q[g])
         ); // R8 R11

         // Irq style and fifo error source
         always @(posedge sys_clk)
         begin
            if (!reset_n)
            begin
               uart_irq_q[g] <= 1'b0;
               line_status_err_q[g] <= 1'b0;
            end
            else
            begin
               // Pulse mode gives one cycle per rising request
               if (opt_q[5*g+3])
                  uart_irq_q[g] <= uart_irq_req[g] & ~irq_req_prev_q[g]; // R6
               else
                  uart_irq_q[g] <= uart_irq_req[g]; // R6
               // Revised indicator replaces the original in bit 7
               line_status_err_q[g] <= opt_q[5*g+2] ? rx_fifo_err_new[g] : rx_fifo_err_orig[g]; // R7
            end
         end
      end
   endgenerate

   // Read data mux; reserved bits read as zero
   reg [7:0] rd_byte;
   always @*
   begin
      rd_byte = 8'h00;
      case (bank)
         `BANK_UART_D, `BANK_UART_E, `BANK_UART_F:
         begin
            if (idx == `IDX_ACTIVATE)
               rd_byte = {7'h00, act_q[bank]};
            else if (idx == `IDX_BASE_HIGH)
               rd_byte = {4'h0, base_hi_q[4*bank +: 4]};
            else if (idx == `IDX_BASE_LOW)
               rd_byte = {base_lo_q[5*bank +: 5], 3'h0}; // R12
            else if (idx == `IDX_IRQ_SELECT)
               rd_byte = {4'h0, irq_sel_q[4*bank +: 4]}; // R4
            else if (idx == `IDX_OPTIONS && bank == `BANK_UART_D)
               rd_byte = {opt_q[4:3], opt_q[2], 3'h0, opt_q[1:0]};
            else if (idx == `IDX_OPTIONS && bank == `BANK_UART_E)
               rd_byte = {1'b0, opt_q[8], opt_q[7], 3'h0, opt_q[6:5]}; // R9
            else
               rd_byte = 8'h00;
         end
         default:
         begin
            if (idx == `IDX_INT_STATUS)
               rd_byte = {2'h0, int_stat_q};
            else if (idx == `IDX_INT_MASK)
               rd_byte = {2'h0, int_mask_q};
            else
               rd_byte = 8'h00;
         end
      endcase
   end

   // Slave answer: ack one cycle after the request, dropped after one cycle
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         // Unmapped addresses answer with zero, writes there are dropped
         if (bus_req & ~wb_ack_o)
            wb_dat_o <= {24'h000000, rd_byte};
      end
   end

   // Pin synchronisers
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         io_meta_q <= 13'h0000;
         io_sync_q <= 13'h0000;
         ref_meta_q <= 1'b0;
         ref_sync_q <= 1'b0;
         irq_req_prev_q <= 2'h0;
      end
      else
      begin
         io_meta_q <= {io_addr_valid, io_addr};
         io_sync_q <= io_meta_q;
         ref_meta_q <= ref_tick;
         ref_sync_q <= ref_meta_q;
         irq_req_prev_q <= uart_irq_req;
      end
   end

   // Configuration outputs and host address decode
   integer d;
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         dev_active_q <= 3'h0;
         dev_base_q <= 36'h000000000;
         irq_line_q <= 12'h000;
         io_select_q <= 3'h0;
         rx_delay_en_q <= 1'b0;
         base_ok_q <= {NUM_DEV{1'b1}};
      end
      else
      begin
         for (d = 0; d < NUM_DEV; d = d + 1)
         begin
            dev_active_q[d] <= act_q[d]; // R1
            dev_base_q[12*d +: 12] <= base_full[d];
            irq_line_q[4*d +: 4] <= irq_sel_q[4*d +: 4]; // R4
            // Inactive or out-of-window devices claim nothing; 8-byte window
            io_select_q[d] <= io_sync_q[12] & act_q[d] & base_ok[d]
               & (io_sync_q[11:3] == base_full[d][11:3]); // R2
         end
         base_ok_q <= base_ok;
         // Delay is inserted while bit 7 is clear
         rx_delay_en_q <= ~opt_q[4]; // R9
      end
   end

   // Events: bits 2..0 activate change, bits 5..3 base left the window
   wire [5:0] int_set = {base_ok_q & ~base_ok, act_evt};
   wire stat_rd = rd_commit & hit(bank, idx, `BANK_INT, `IDX_INT_STATUS);

   // Sticky status, read clears, a new event wins over the clear
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         int_stat_q <= 6'h00;
         int_mask_q <= 6'h00;
         irq_o <= 1'b0;
      end
      else
      begin
         int_stat_q <= (stat_rd ? 6'h00 : int_stat_q) | int_set;
         if (wr_commit & hit(bank, idx, `BANK_INT, `IDX_INT_MASK))
            int_mask_q <= wb_dat_i[5:0];
         irq_o <= |(int_stat_q & int_mask_q);
      end
   end

endmodule
`default_nettype wire

// ===== uart_ldev_cfg_props.sv
// Port checks for the UART configuration bank.
// Assumes a classic Wishbone master and reset held for two edges.
`timescale 1ns/10ps
`default_nettype none
module uart_ldev_cfg_props
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [2:0] dev_active_q,
   input wire logic [35:0] dev_base_q,
   input wire logic [11:0] irq_line_q,
   input wire logic rx_delay_en_q
);
   // Write committed at this edge
   wire wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   // Outputs are copies of the registers, so reset values show one edge after release
   property p_act_rst;
      $rose(reset_n) |-> dev_active_q == 3'h0;
   endproperty
   a_act_rst: assert property (p_act_rst) else $error("active after reset");
   property p_base_rst;
      $rose(reset_n) |=> dev_base_q == 36'h2e83e82e0;
   endproperty
   a_base_rst: assert property (p_base_rst) else $error("base after reset");
   property p_irq_rst;
      $rose(reset_n) |=> irq_line_q == 12'h343 && rx_delay_en_q;
   endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("irq select after reset");
   property p_act_wr;
      wr_ok && wb_adr_i == 12'h0c0 |-> ##2 dev_active_q[0] == $past(wb_dat_i[0], 2);
   endproperty
   a_act_wr: assert property (p_act_wr) else $error("activate write");
   property p_base_align;
      dev_base_q[2:0] == 3'h0 && dev_base_q[14:12] == 3'h0 && dev_base_q[26:24] == 3'h0;
   endproperty
   a_base_align: assert property (p_base_align) else $error("base unaligned");
   property p_irq_wr;
      wr_ok && wb_adr_i == 12'h5c0 |-> ##2 irq_line_q[7:4] == $past(wb_dat_i[3:0], 2);
   endproperty
   a_irq_wr: assert property (p_irq_wr) else $error("irq select write");
   // Delay output follows the option register one edge later
   property p_delay;
      wr_ok && wb_adr_i == 12'h3c0 |-> ##2 rx_delay_en_q == !$past(wb_dat_i[7], 2);
   endproperty
   a_delay: assert property (p_delay) else $error("receive delay");
   property p_rsv_rd;
      wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   a_rsv_rd: assert property (p_rsv_rd) else $error("reserved read bits");
endmodule
bind uart_ldev_cfg uart_ldev_cfg_props i_props
(
   .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_active_q(dev_active_q),
   .dev_base_q(dev_base_q), .irq_line_q(irq_line_q), .rx_delay_en_q(rx_delay_en_q)
);
`default_nettype wire

// ===== uart_host_model.sv
// Host side pins: reference ticks and host I/O address cycles.
// Assumes one sys_clk domain; reference stands still when not running.
`timescale 1ns/10ps
`default_nettype none
module uart_host_model
(
   input wire logic sys_clk,
   input wire logic ref_run,
   input wire logic [11:0] host_addr,
   input wire logic host_valid,
   output logic ref_tick,
   output logic [11:0] io_addr,
   output logic io_addr_valid
);
   logic [1:0] phase_q = 2'h0; // Reference phase
   initial {ref_tick, io_addr, io_addr_valid} = 14'h0;
   // Tick every fourth cycle, near the 24 MHz rate
   always @(posedge sys_clk)
   begin
      phase_q <= ref_run ? phase_q + 2'h1 : 2'h0;
      ref_tick <= ref_run && phase_q == 2'h3;
      io_addr_valid <= host_valid;
      // Released lines toggle so a stale address never decodes
      io_addr <= host_valid ? host_addr : ~io_addr;
   end
endmodule
`default_nettype wire

// ===== uart_ldev_cfg_tb.sv
// Self-checking bench for the UART configuration bank.
// Assumes the bound checker and the host pin model beside it.
`timescale 1ns/10ps
`default_nettype none
module uart_ldev_cfg_tb;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h0;
   logic [31:0] wdat = 32'h0;
   logic [1:0] req = 2'h0;
   logic [1:0] err_o = 2'h0;
   logic [1:0] err_n = 2'h0;
   logic ref_run = 1'b0;
   logic [11:0] host_addr = 12'h0;
   logic host_valid = 1'b0;
   logic [31:0] rdat;
   logic ack, irq, ref_tick, io_valid, rx_dly;
   logic [11:0] io_addr, irq_line;
   logic [2:0] act, io_sel;
   logic [35:0] base;
   logic [1:0] uirq, lse, ctick;
   logic [7:0] rd, v;
   int errors = 0;
   int check_count = 0;
   int n, t, cnt, cnt2;
   // Address and reset value of each device register, F options and one unmapped place, then the interrupt mask
   logic [19:0] rst_tab [17] = '{20'h0c000, 20'h18002, 20'h184e0, 20'h1c003, 20'h3c000, 20'h4c000,
      20'h58003, 20'h584e8, 20'h5c004, 20'h7c000, 20'h8c000, 20'h98002, 20'h984e8, 20'h9c003,
      20'hbc000, 20'h00400, 20'hc1000};
   uart_ldev_cfg i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .io_addr(io_addr), .io_addr_valid(io_valid), .ref_tick(ref_tick),
      .uart_irq_req(req), .rx_fifo_err_orig(err_o), .rx_fifo_err_new(err_n), .dev_active_q(act),
      .dev_base_q(base), .irq_line_q(irq_line), .io_select_q(io_sel), .uart_irq_q(uirq),
      .line_status_err_q(lse), .rx_delay_en_q(rx_dly), .uart_clk_tick_q(ctick));
   uart_host_model i_host (.sys_clk(sys_clk), .ref_run(ref_run), .host_addr(host_addr),
      .host_valid(host_valid), .ref_tick(ref_tick), .io_addr(io_addr), .io_addr_valid(io_valid));
   initial forever #5 sys_clk = ~sys_clk;
   // Writable bits of each register
   function automatic logic [7:0] wmask(input logic [11:0] a);
      case (a[9:2])
         8'h30: wmask = a[11:10] == 2'h3 ? 8'h00 : 8'h01;
         8'h60: wmask = 8'h0f;
         8'h61: wmask = 8'hf8;
         8'h70: wmask = 8'h0f;
         8'hf0: wmask = a[11:10] == 2'h0 ? 8'he3 : (a[11:10] == 2'h1 ? 8'h63 : 8'h00);
         default: wmask = 8'h00;
      endcase
   endfunction
   // Divider output over 156 reference ticks
   function automatic int exp_ticks(input int code);
      exp_ticks = code == 0 ? 156 / 13 : (code == 1 ? 156 / 12 : (code == 2 ? 156 : 156 * 8 / 13));
   endfunction
   task automatic chk(input logic [35:0] seen, input logic [35:0] want, input string what);
      check_count++;
      if (seen !== want)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask
   // Classic single cycle; waits for ack, bounded
   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      t = 0;
      @(posedge sys_clk);
      while (ack !== 1'b1 && t < 20)
      begin
         @(posedge sys_clk);
         t++;
      end
      if (t == 20)
         errors++;
      rd = rdat[7:0];
      cyc <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic probe(input logic [11:0] a, input logic want);
      host_addr <= a;
      host_valid <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk(io_sel[0], want, "io select");
      host_valid <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial
   begin
      #300000;
      errors++;
      give_verdict;
   end
   initial
   begin
      void'($urandom(79890));
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      for (n = 0; n < 17; n++)
      begin
         wb(1'b0, rst_tab[n][19:8], 8'h00);
         chk(rd, rst_tab[n][7:0], "reset value");
      end
      $display("test reset values done");
      // Random writes, unmapped place included
      for (n = 0; n < 60; n++)
      begin
         cnt = $urandom_range(15);
         v = 8'($urandom);
         wb(1'b1, rst_tab[cnt][19:8], v);
         wb(1'b0, rst_tab[cnt][19:8], 8'h00);
         chk(rd, v & wmask(rst_tab[cnt][19:8]), "readback");
      end
      $display("test readback done");
      // Interrupt: masked event, unmask, read clears
      wb(1'b1, 12'h580, 8'h03);
      wb(1'b1, 12'hc10, 8'h00);
      wb(1'b1, 12'h0c0, 8'h00);
      wb(1'b0, 12'hc00, 8'h00);
      wb(1'b1, 12'h0c0, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0, "masked irq");
      wb(1'b1, 12'hc10, 8'h3f);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b1, "irq");
      wb(1'b0, 12'hc00, 8'h00);
      chk(rd, 8'h01, "status");
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0, "cleared irq");
      wb(1'b1, 12'h580, 8'h00);
      wb(1'b0, 12'hc00, 8'h00);
      chk(rd, 8'h10, "low base status");
      $display("test interrupt done");
      // Irq style, error source and receive delay in both settings
      for (n = 0; n < 2; n++)
      begin
         v = n ? 8'he0 : 8'h00;
         wb(1'b1, 12'h3c0, v);
         wb(1'b1, 12'h7c0, v);
         err_o <= 2'($urandom);
         err_n <= 2'($urandom);
         req <= 2'h0;
         repeat (3) @(posedge sys_clk);
         req <= 2'h3;
         cnt = 0;
         repeat (6)
         begin
            @(posedge sys_clk);
            cnt += uirq[0];
         end
         chk(cnt, n ? 1 : 5, "irq style");
         chk(lse, n ? err_n : err_o, "fifo error");
         chk(rx_dly, !n, "receive delay");
      end
      $display("test options done");
      // Clock select codes on D and E
      for (n = 0; n < 4; n++)
      begin
         wb(1'b1, 12'h3c0, 8'(n));
         wb(1'b1, 12'h7c0, 8'(n));
         ref_run <= 1'b1;
         cnt = 0;
         cnt2 = 0;
         for (t = 0; t < 640; t++)
         begin
            @(posedge sys_clk);
            if (t == 623)
               ref_run <= 1'b0;
            cnt += ctick[0];
            cnt2 += ctick[1];
         end
         chk(cnt + 1 >= exp_ticks(n) && cnt <= exp_ticks(n) + 1, 1'b1, "d ticks");
         chk(cnt2 + 1 >= exp_ticks(n) && cnt2 <= exp_ticks(n) + 1, 1'b1, "e ticks");
      end
      $display("test clock select done");
      // Address decode at window edges
      wb(1'b1, 12'h180, 8'h03);
      wb(1'b1, 12'h184, 8'hff);
      @(posedge sys_clk);
      chk(base[11:0], 12'h3f8, "base");
      probe(12'h3f8, 1'b1);
      probe(12'h3ff, 1'b1);
      probe(12'h3f7, 1'b0);
      probe(12'h400, 1'b0);
      wb(1'b1, 12'h0c0, 8'h00);
      probe(12'h3f8, 1'b0);
      wb(1'b1, 12'h0c0, 8'h01);
      wb(1'b1, 12'h180, 8'h00);
      probe(12'h0f8, 1'b0);
      $display("test decode done");
      // Second reset in mid-run
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(act, 3'h0, "active");
      chk(base, 36'h2e83e82e0, "base reset");
      chk(irq_line, 12'h343, "irq lines");
      $display("test second reset done");
      give_verdict;
   end
endmodule
`default_nettype wire
